// ==== inc/asb_pkg.sv ====
// Purpose: Shared constants of the angle sensor register bank.
// Assumes: Byte-wide register port driven by the serial link engine.
// Notes:   Offsets are register numbers on the serial link.
package asb_pkg;
  // Register offsets.
  localparam logic [3:0] ADDR_CONTROL_ONE  = 4'h0;
  localparam logic [3:0] ADDR_X_LOW        = 4'h1;
  localparam logic [3:0] ADDR_X_HIGH       = 4'h2;
  localparam logic [3:0] ADDR_Y_LOW        = 4'h3;
  localparam logic [3:0] ADDR_Y_HIGH       = 4'h4;
  localparam logic [3:0] ADDR_FRAME_STATUS = 4'h5;
  localparam logic [3:0] ADDR_PHASE_INVERT = 4'h6;
  localparam logic [3:0] ADDR_ANGLE_TEST   = 4'h7;
  localparam logic [3:0] ADDR_RESERVED_8   = 4'h8;
  localparam logic [3:0] ADDR_RESERVED_9   = 4'h9;
  localparam logic [3:0] ADDR_TEST_PATH    = 4'hc;
  localparam logic [3:0] ADDR_IDENT        = 4'hd;
  localparam logic [3:0] ADDR_GUARD_KEY    = 4'he;
  localparam logic [3:0] ADDR_FAULT_NODE   = 4'hf;
  // Field positions.
  localparam int BIT_SNAPSHOT_MODE = 0;
  localparam int BIT_AUTO_REFRESH  = 1;
  localparam int BIT_SPIKE_FILTER  = 3;
  localparam int BIT_REFRESH_TOG   = 4;
  localparam int BIT_NOT_BRIDGE    = 5;
  localparam int BIT_SUPPLY_FAULT  = 6;
  localparam int BIT_FILTER_INVERT = 7;
  localparam int BIT_ANGLE_TEST_ON = 6;
  localparam int BIT_TEST_CHANNEL  = 0;
  localparam int BIT_BRIDGE_TEST   = 1;
  localparam int BIT_CONV_TEST     = 2;
  localparam int BIT_FIR_SKIP      = 3;
  localparam int BIT_FILT_SWAPPED  = 4;
  localparam int BIT_FILT_PARALLEL = 5;
  localparam int BIT_Y_INVERT      = 6;
  localparam int BIT_TEMP_PATH     = 7;
  // Reset values and counts.
  localparam logic [7:0] RESET_CONTROL_ONE  = 8'h00;
  localparam logic [7:0] RESET_FRAME_STATUS = 8'h80;
  localparam logic [7:0] RESET_ZERO         = 8'h00;
  localparam logic [7:0] UNLOCK_KEY         = 8'h5a;
  localparam logic [3:0] FRAME_VALID_MIN    = 4'h2;
  localparam logic [3:0] FRAME_RELOAD       = 4'h3;
  localparam logic [6:0] PHASE_WRAP_NORMAL  = 7'h7f;
  localparam logic [6:0] PHASE_WRAP_SKIP    = 7'h1f;
  localparam logic [7:0] REFRESH_COMMAND    = 8'h00;
endpackage

// ==== logic/asb_register_bank.sv ====
// Purpose: Register bank, snapshot buffers, frame counters and line filters.
// Assumes: One 40 MHz clock; serial engine accesses registers on this clock.
// Notes:   Link lines are sampled by three flip-flops and optionally filtered.
`timescale 1ns/100ps

// Function
// - Spike filter bit enables link line filtering.
// - Auto refresh after settle ends angle test.
// - Snapshot mode reads stored buffer values.
// - Four bytes hold signed X and Y.
// - Fault and supply fault bits stick until read out.
// - Supply fault summary ORs all comparators.
// - Not-bridge bit follows multiplexer controls.
// - Refresh toggle inverts on every refresh.
// - Frame count counts pairs, clears on events.
// - Frame count valid from two, reloads three.
// - Frame count runs fourfold with fir skip.
// - Filter input invert bit drives data path.
// - Decimation phase settable, wraps 31 when skipping.
// - Angle test replaces X/Y with test values.
// - Temperature path carries X, auto applies.
// - Y stream invert reverses rotation.
// - Parallel and swapped filter routing bits.
// - Converter test beats bridge test.
// - Test channel selects X or Y.
// - Locked fields writable only with key set.
// - Sticky regulator and supply fault flags.
// - Node index holds the slave number.
// - Refresh copies all values into snapshots in snapshot mode.
// - All-zero command byte is the refresh.
module asb_register_bank #(
  parameter logic [7:0] IDENT_CODE = 8'h3c  // Arbitrary identification value.
) (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // Link lines from the pins.
  input  wire logic        i_sck,
  input  wire logic        i_cs_n,
  input  wire logic        i_data,
  output logic             o_sck,
  output logic             o_cs_n,
  output logic             o_data,
  // Register port from the serial engine.
  input  wire logic        i_cmd_valid,
  input  wire logic [7:0]  i_cmd_byte,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic [7:0]       o_reg_rdata,
  // Data path.
  input  wire logic        i_decim_tick,
  input  wire logic [15:0] i_x_value,
  input  wire logic [15:0] i_y_value,
  input  wire logic        i_mux_ok,
  input  wire logic [5:0]  i_fault_cmp,
  // Controls to the analog and filter path.
  output logic             o_filter_input_invert,
  output logic             o_y_stream_invert,
  output logic             o_filters_parallel,
  output logic             o_filters_swapped,
  output logic             o_fir_skip,
  output logic             o_converter_to_test_pins,
  output logic             o_bridge_to_test_pins,
  output logic             o_test_channel_sel,
  output logic             o_temperature_path_on,
  output logic             o_angle_test_on,
  output logic [2:0]       o_test_value_x_sel,
  output logic [2:0]       o_test_value_y_sel,
  output logic [1:0]       o_node_index,
  output logic             o_spike_filter_select
);
  logic [7:0]  control_one;
  logic [7:0]  test_path_control;
  logic [7:0]  write_guard_key;
  logic [5:0]  fault_flags;
  logic [1:0]  node_index;
  logic        supply_fault;
  logic        refresh_toggle;
  logic [3:0]  frame_count;
  logic [6:0]  decimation_phase;
  logic        filter_input_invert;
  logic [6:0]  angle_test_control;
  logic [15:0] x_imm;
  logic [15:0] y_imm;
  logic [15:0] x_snap;
  logic [15:0] y_snap;
  logic [7:0]  status_snap;
  logic [6:0]  phase_snap;
  logic        auto_pending;
  logic [2:0]  sync_sck;
  logic [2:0]  sync_cs;
  logic [2:0]  sync_data;
  logic [2:0]  hist_sck;
  logic [2:0]  hist_cs;
  logic [2:0]  hist_data;
  logic        unlocked;
  logic        wr_phase;
  logic        wr_angle;
  logic        frame_event;
  logic        auto_fire;
  logic        refresh;
  logic        snapshot_mode;
  logic        fir_skip;
  logic [6:0]  phase_wrap;
  logic        not_bridge;
  logic [7:0]  status_imm;
  logic        angle_change;

  function automatic logic majority(input logic [2:0] s);
    majority = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
  endfunction

  function automatic logic wr_at(input logic wr, input logic [3:0] a, input logic [3:0] t);
    wr_at = wr && (a == t);
  endfunction

  // Three-stage synchronisers on the raw link pins.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_sck  <= 3'h0;
      sync_cs   <= 3'h7;
      sync_data <= 3'h7;
    end else begin
      sync_sck  <= {sync_sck[1:0], i_sck};
      sync_cs   <= {sync_cs[1:0], i_cs_n};
      sync_data <= {sync_data[1:0], i_data};
    end
  end

  // Sample history; a level counts once the last two stages agree.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hist_sck  <= 3'h0;
      hist_cs   <= 3'h7;
      hist_data <= 3'h7;
    end else begin
      if (sync_sck[1] == sync_sck[2]) begin
        hist_sck <= {hist_sck[1:0], sync_sck[2]};
      end
      if (sync_cs[1] == sync_cs[2]) begin
        hist_cs <= {hist_cs[1:0], sync_cs[2]};
      end
      if (sync_data[1] == sync_data[2]) begin
        hist_data <= {hist_data[1:0], sync_data[2]};
      end
    end
  end

  // Filtered lines take a two-of-three vote, unfiltered the newest sample.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sck  <= 1'b0;
      o_cs_n <= 1'b1;
      o_data <= 1'b1;
    end else if (control_one[asb_pkg::BIT_SPIKE_FILTER]) begin
      o_sck  <= majority(hist_sck);
      o_cs_n <= majority(hist_cs);
      o_data <= majority(hist_data);
    end else begin
      o_sck  <= hist_sck[0];
      o_cs_n <= hist_cs[0];
      o_data <= hist_data[0];
    end
  end

  assign unlocked      = (write_guard_key == asb_pkg::UNLOCK_KEY);
  assign wr_phase      = wr_at(i_reg_wr, i_reg_addr, asb_pkg::ADDR_PHASE_INVERT);
  assign wr_angle      = wr_at(i_reg_wr, i_reg_addr, asb_pkg::ADDR_ANGLE_TEST);
  assign snapshot_mode = control_one[asb_pkg::BIT_SNAPSHOT_MODE];
  assign fir_skip      = test_path_control[asb_pkg::BIT_FIR_SKIP];
  assign phase_wrap    = fir_skip ? asb_pkg::PHASE_WRAP_SKIP : asb_pkg::PHASE_WRAP_NORMAL;
  assign frame_event   = i_decim_tick && (decimation_phase >= phase_wrap);
  assign auto_fire     = auto_pending && (frame_count >= asb_pkg::FRAME_VALID_MIN);
  assign refresh       = (i_cmd_valid && (i_cmd_byte == asb_pkg::REFRESH_COMMAND))
                         || auto_fire;
  assign angle_change  = (wr_angle && (i_reg_wdata[asb_pkg::BIT_ANGLE_TEST_ON]
                          != angle_test_control[asb_pkg::BIT_ANGLE_TEST_ON]))
                         || (auto_fire && angle_test_control[asb_pkg::BIT_ANGLE_TEST_ON]);
  assign not_bridge    = angle_test_control[asb_pkg::BIT_ANGLE_TEST_ON]
                         || test_path_control[asb_pkg::BIT_TEMP_PATH] || !i_mux_ok;
  assign status_imm    = {1'b0, supply_fault, not_bridge, refresh_toggle, frame_count};

  // Guard key; any value but the unlock key keeps locked fields locked.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      write_guard_key <= asb_pkg::RESET_ZERO;
    end else if (wr_at(i_reg_wr, i_reg_addr, asb_pkg::ADDR_GUARD_KEY)) begin
      write_guard_key <= i_reg_wdata;
    end
  end

  // Locked control registers.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      control_one       <= asb_pkg::RESET_CONTROL_ONE;
      test_path_control <= asb_pkg::RESET_ZERO;
      node_index        <= 2'h0;
    end else if (i_reg_wr) begin
      if (unlocked && (i_reg_addr == asb_pkg::ADDR_CONTROL_ONE)) begin
        control_one <= i_reg_wdata & 8'h0b;
      end
      if (unlocked && (i_reg_addr == asb_pkg::ADDR_TEST_PATH)) begin
        test_path_control <= i_reg_wdata;
      end
      if (unlocked && (i_reg_addr == asb_pkg::ADDR_FAULT_NODE)) begin
        node_index <= i_reg_wdata[1:0];
      end
    end
  end

  // Angle test register; auto refresh turns the test off.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      angle_test_control <= 7'h00;
    end else if (wr_angle) begin
      angle_test_control <= i_reg_wdata[6:0];
    end else if (auto_fire) begin
      angle_test_control[asb_pkg::BIT_ANGLE_TEST_ON] <= 1'b0;
    end
  end

  // Auto refresh is armed when a test or temperature readout starts.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      auto_pending <= 1'b0;
    end else if (!control_one[asb_pkg::BIT_AUTO_REFRESH] || auto_fire) begin
      auto_pending <= 1'b0;
    end else if ((wr_angle && i_reg_wdata[asb_pkg::BIT_ANGLE_TEST_ON])
                 || (unlocked && wr_at(i_reg_wr, i_reg_addr, asb_pkg::ADDR_TEST_PATH)
                     && i_reg_wdata[asb_pkg::BIT_TEMP_PATH])) begin
      auto_pending <= 1'b1;
    end
  end

  // Filter input inversion.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      filter_input_invert <= 1'b0;
    end else if (wr_phase) begin
      filter_input_invert <= i_reg_wdata[asb_pkg::BIT_FILTER_INVERT];
    end
  end

  // Decimation phase; a write sets the phase of the decimation.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      decimation_phase <= 7'h00;
    end else if (wr_phase) begin
      decimation_phase <= i_reg_wdata[6:0];
    end else if (auto_fire) begin
      decimation_phase <= 7'h00;
    end else if (frame_event) begin
      decimation_phase <= 7'h00;
    end else if (i_decim_tick) begin
      decimation_phase <= 7'(decimation_phase + 7'h01);
    end
  end

  // Frame counter with reload past overflow.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      frame_count <= asb_pkg::RESET_FRAME_STATUS[3:0];
    end else if (wr_phase || angle_change || auto_fire) begin
      frame_count <= 4'h0;
    end else if (frame_event) begin
      if (frame_count == 4'hf) begin
        frame_count <= asb_pkg::FRAME_RELOAD;
      end else begin
        frame_count <= 4'(frame_count + 4'h1);
      end
    end
  end

  // Immediate X and Y values latched per new pair.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      x_imm <= 16'h0000;
      y_imm <= 16'h0000;
    end else if (frame_event) begin
      x_imm <= i_x_value;
      y_imm <= i_y_value;
    end
  end

  // Refresh toggle inverts on every refresh.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      refresh_toggle <= 1'b0;
    end else if (refresh) begin
      refresh_toggle <= !refresh_toggle;
    end
  end

  // Snapshot buffers load together in update mode.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      x_snap      <= 16'h0000;
      y_snap      <= 16'h0000;
      status_snap <= asb_pkg::RESET_FRAME_STATUS;
      phase_snap  <= 7'h00;
    end else if (refresh && snapshot_mode) begin
      x_snap      <= x_imm;
      y_snap      <= y_imm;
      status_snap <= status_imm;
      phase_snap  <= decimation_phase;
    end
  end

  // Sticky faults; a new fault in the read cycle wins over the clear.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fault_flags <= 6'h00;
    end else if (wr_at(i_reg_rd, i_reg_addr, asb_pkg::ADDR_FAULT_NODE)) begin
      fault_flags <= i_fault_cmp;
    end else begin
      fault_flags <= fault_flags | i_fault_cmp;
    end
  end

  // Supply summary; it follows the same set-wins rule on its own read.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      supply_fault <= 1'b0;
    end else if (wr_at(i_reg_rd, i_reg_addr, asb_pkg::ADDR_FRAME_STATUS)) begin
      supply_fault <= |i_fault_cmp;
    end else begin
      supply_fault <= supply_fault | (|i_fault_cmp);
    end
  end

  // Read data; update-type fields come from snapshots in update mode.
  always_comb begin
    o_reg_rdata = 8'h00;
    case (i_reg_addr)
      asb_pkg::ADDR_CONTROL_ONE:  o_reg_rdata = control_one;
      asb_pkg::ADDR_X_LOW:        o_reg_rdata = snapshot_mode ? x_snap[7:0] : x_imm[7:0];
      asb_pkg::ADDR_X_HIGH:       o_reg_rdata = snapshot_mode ? x_snap[15:8] : x_imm[15:8];
      asb_pkg::ADDR_Y_LOW:        o_reg_rdata = snapshot_mode ? y_snap[7:0] : y_imm[7:0];
      asb_pkg::ADDR_Y_HIGH:       o_reg_rdata = snapshot_mode ? y_snap[15:8] : y_imm[15:8];
      asb_pkg::ADDR_FRAME_STATUS: o_reg_rdata = snapshot_mode
                                    ? {1'b0, supply_fault, status_snap[5], refresh_toggle,
                                       status_snap[3:0]}
                                    : status_imm;
      asb_pkg::ADDR_PHASE_INVERT: o_reg_rdata = {filter_input_invert,
                                    snapshot_mode ? phase_snap : decimation_phase};
      asb_pkg::ADDR_ANGLE_TEST:   o_reg_rdata = {1'b0, angle_test_control};
      asb_pkg::ADDR_TEST_PATH:    o_reg_rdata = test_path_control;
      asb_pkg::ADDR_IDENT:        o_reg_rdata = IDENT_CODE;
      asb_pkg::ADDR_GUARD_KEY:    o_reg_rdata = write_guard_key;
      asb_pkg::ADDR_FAULT_NODE:   o_reg_rdata = {fault_flags, node_index};
      default:                    o_reg_rdata = 8'h00;
    endcase
  end

  // Control outputs.
  assign o_spike_filter_select    = control_one[asb_pkg::BIT_SPIKE_FILTER];
  assign o_filter_input_invert    = filter_input_invert;
  assign o_y_stream_invert        = test_path_control[asb_pkg::BIT_Y_INVERT];
  assign o_filters_parallel       = test_path_control[asb_pkg::BIT_FILT_PARALLEL];
  assign o_filters_swapped        = test_path_control[asb_pkg::BIT_FILT_SWAPPED];
  assign o_fir_skip               = fir_skip;
  assign o_converter_to_test_pins = test_path_control[asb_pkg::BIT_CONV_TEST];
  assign o_bridge_to_test_pins    = test_path_control[asb_pkg::BIT_BRIDGE_TEST]
                                    && !test_path_control[asb_pkg::BIT_CONV_TEST];
  assign o_test_channel_sel       = test_path_control[asb_pkg::BIT_TEST_CHANNEL];
  assign o_temperature_path_on    = test_path_control[asb_pkg::BIT_TEMP_PATH];
  assign o_angle_test_on          = angle_test_control[asb_pkg::BIT_ANGLE_TEST_ON];
  assign o_test_value_y_sel       = angle_test_control[5:3];
  assign o_test_value_x_sel       = angle_test_control[2:0];
  assign o_node_index             = node_index;
endmodule

// ==== bench/asb_register_bank_sva.sv ====
// Purpose: Port-level checks of the angle sensor register bank.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Read data is combinational, so reads are checked in the same cycle.
`timescale 1ns/100ps
module asb_register_bank_chk (
  // Clock and reset.
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  // Link lines.
  input wire logic        i_sck,
  input wire logic        i_cs_n,
  input wire logic        o_sck,
  input wire logic        o_cs_n,
  input wire logic        i_data,
  input wire logic        o_data,
  // Register port.
  input wire logic        i_cmd_valid,
  input wire logic [7:0]  i_cmd_byte,
  input wire logic        i_reg_wr,
  input wire logic [3:0]  i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic [7:0]  o_reg_rdata,
  input wire logic [5:0]  i_fault_cmp,
  // Controls.
  input wire logic        o_y_stream_invert,
  input wire logic        o_filters_parallel,
  input wire logic        o_filters_swapped,
  input wire logic        o_fir_skip,
  input wire logic        o_converter_to_test_pins,
  input wire logic        o_bridge_to_test_pins,
  input wire logic        o_test_channel_sel,
  input wire logic        o_temperature_path_on,
  input wire logic        o_angle_test_on,
  input wire logic [2:0]  o_test_value_x_sel,
  input wire logic [2:0]  o_test_value_y_sel,
  input wire logic [1:0]  o_node_index,
  input wire logic        o_spike_filter_select
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  AST_BRIDGE_PRIO: assert property (
    o_converter_to_test_pins |-> !o_bridge_to_test_pins) else $error("bridge path not forced off");
  AST_LINK_SCK: assert property (
    i_sck [*4] |-> ##[0:6] o_sck) else $error("link clock not passed on");
  AST_LINK_CS: assert property (
    (!i_cs_n) [*4] |-> ##[0:6] !o_cs_n) else $error("chip select not passed on");
  AST_LINK_DATA: assert property (
    (!i_data) [*4] |-> ##[0:6] !o_data) else $error("data line not passed on");
  AST_ANGLE_WRITE: assert property (
    (i_reg_wr && i_reg_addr == asb_pkg::ADDR_ANGLE_TEST) |=> (o_angle_test_on == $past(i_reg_wdata[6])
    && {o_test_value_y_sel, o_test_value_x_sel} == $past(i_reg_wdata[5:0]))) else $error("angle test write");
  AST_REFRESH_TOGGLE: assert property (
    (i_cmd_valid && i_cmd_byte == 8'h00 && i_reg_addr == asb_pkg::ADDR_FRAME_STATUS) ##1
    (i_reg_addr == asb_pkg::ADDR_FRAME_STATUS) |-> o_reg_rdata[4] != $past(o_reg_rdata[4]))
    else $error("refresh toggle did not invert");
  AST_FAULT_STICKY: assert property (
    (i_fault_cmp != 6'h00) ##1 (i_reg_addr == asb_pkg::ADDR_FAULT_NODE) |->
    (o_reg_rdata[7:2] & $past(i_fault_cmp)) == $past(i_fault_cmp)) else $error("fault flag missing");
  AST_SUPPLY_SUMMARY: assert property (
    (i_fault_cmp != 6'h00) ##1 (i_reg_addr == asb_pkg::ADDR_FRAME_STATUS) |-> o_reg_rdata[6])
    else $error("supply summary missing");
  AST_CTRL_READ: assert property (
    (i_reg_addr == asb_pkg::ADDR_CONTROL_ONE) |-> (o_reg_rdata[3] == o_spike_filter_select
    && o_reg_rdata[7:4] == 4'h0)) else $error("control readback mismatch");
  AST_NODE_READ: assert property (
    (i_reg_addr == asb_pkg::ADDR_FAULT_NODE) |-> o_reg_rdata[1:0] == o_node_index)
    else $error("node index readback mismatch");
  AST_TEST_READ: assert property (
    (i_reg_addr == asb_pkg::ADDR_TEST_PATH) |-> {o_reg_rdata[7:2], o_reg_rdata[0]} ==
    {o_temperature_path_on, o_y_stream_invert, o_filters_parallel, o_filters_swapped, o_fir_skip,
    o_converter_to_test_pins, o_test_channel_sel}) else $error("test path readback mismatch");
endmodule

bind asb_register_bank asb_register_bank_chk u_chk (.*);

// ==== bench/asb_host_link.sv ====
// Purpose: Host side of the three-wire serial link.
// Assumes: Link clock period 200 ns, idle low outside frames.
// Notes:   The released data line returns to its pull-up level.
`timescale 1ns/100ps
module asb_host_link (
  // Link lines towards the device.
  output logic o_sck,
  output logic o_cs_n,
  output logic o_data
);
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_data = 1'b1;
  end
  // Sends one whole byte, most significant bit first.
  task automatic send_frame(input logic [7:0] byte_v);
    #7;
    o_cs_n = 1'b0;
    #300;
    for (int i = 7; i >= 0; i--) begin
      o_data = byte_v[i];
      #100;
      o_sck = 1'b1;
      #100;
      o_sck = 1'b0;
    end
    #300;
    o_cs_n = 1'b1;
    o_data = 1'b1;
  endtask
endmodule

// ==== bench/asb_testbench.sv ====
// Purpose: Self-checking bench of the angle sensor register bank.
// Assumes: Register port driven on the falling clock edge.
// Notes:   Frame counting runs with the fir skip set, 32 ticks per pair.
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module testbench;
  localparam logic [7:0] ID = 8'h96;  // Arbitrary identification value.
  logic i_clk = 0, i_arst_n = 0, i_cmd_valid = 0, i_reg_wr = 0, i_reg_rd = 0;
  logic i_decim_tick = 0, i_mux_ok = 1, i_sck, i_cs_n, i_data;
  logic [7:0] i_cmd_byte = 0, i_reg_wdata = 0, o_reg_rdata;
  logic [3:0] i_reg_addr = 0;
  logic [15:0] i_x_value = 0, i_y_value = 0;
  logic [5:0] i_fault_cmp = 0;
  logic o_sck, o_cs_n, o_data, o_filter_input_invert, o_y_stream_invert, o_filters_parallel;
  logic o_filters_swapped, o_fir_skip, o_converter_to_test_pins, o_bridge_to_test_pins;
  logic o_test_channel_sel, o_temperature_path_on, o_angle_test_on, o_spike_filter_select;
  logic [2:0] o_test_value_x_sel, o_test_value_y_sel;
  logic [1:0] o_node_index;
  int n_fail = 0, comparisons = 0, cycles = 0;

  always #12.5 i_clk = ~i_clk;
  asb_register_bank #(.IDENT_CODE(ID)) dut (.*);
  asb_host_link host (.o_sck(i_sck), .o_cs_n(i_cs_n), .o_data(i_data));

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_clk);
    i_reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(negedge i_clk);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    #2;
    `CHK(o_reg_rdata & m, e)
    @(negedge i_clk);
    i_reg_rd = 1'b0;
  endtask
  task automatic cmd(input logic [7:0] c);
    @(negedge i_clk);
    i_cmd_valid = 1'b1;
    i_cmd_byte = c;
    i_reg_addr = 4'h5;
    @(negedge i_clk);
    i_cmd_valid = 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge i_clk);
      i_decim_tick = 1'b1;
      @(negedge i_clk);
      i_decim_tick = 1'b0;
    end
  endtask
  task automatic fault(input logic [3:0] a);
    @(negedge i_clk);
    i_fault_cmp = 6'h24;
    i_reg_addr = a;
    @(negedge i_clk);
    i_fault_cmp = 6'h00;
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    repeat (8) @(negedge i_clk);
    i_arst_n = 1'b1;
    host.send_frame(8'hc3);
    repeat (8) @(negedge i_clk);
    `CHK({o_sck, o_cs_n, o_data}, 3'b011)
    rd(4'h5, 8'h5f, 8'h00);
    rd(4'hd, 8'hff, ID);
    wr(4'hd, 8'h00);
    rd(4'hd, 8'hff, ID);
    rd(4'ha, 8'hff, 8'h00);
    wr(4'h0, 8'h08);
    rd(4'h0, 8'hff, 8'h00);
    wr(4'he, 8'h5a);
    wr(4'h0, 8'h08);
    `CHK(o_spike_filter_select, 1'b1)
    host.send_frame(8'h0f);
    repeat (8) @(negedge i_clk);
    `CHK({o_sck, o_cs_n, o_data}, 3'b011)
    wr(4'hc, 8'h06);
    `CHK({o_converter_to_test_pins, o_bridge_to_test_pins}, 2'b10)
    wr(4'hc, 8'hf9);
    `CHK({o_temperature_path_on, o_y_stream_invert, o_filters_parallel, o_filters_swapped, o_fir_skip, o_converter_to_test_pins, o_bridge_to_test_pins, o_test_channel_sel}, 8'hf9)
    wr(4'hc, 8'h08);
    wr(4'hf, 8'h03);
    `CHK(o_node_index, 2'h3)
    i_x_value = 16'h8123;
    i_y_value = 16'h7f45;
    wr(4'h6, 8'h9e);
    rd(4'h6, 8'hff, 8'h9e);
    `CHK(o_filter_input_invert, 1'b1)
    tick(2);
    rd(4'h6, 8'hff, 8'h80);
    rd(4'h5, 8'h0f, 8'h01);
    rd(4'h1, 8'hff, 8'h23);
    rd(4'h2, 8'hff, 8'h81);
    rd(4'h3, 8'hff, 8'h45);
    rd(4'h4, 8'hff, 8'h7f);
    tick(32 * 14);
    rd(4'h5, 8'h0f, 8'h0f);
    tick(32);
    rd(4'h5, 8'h0f, 8'h03);
    wr(4'h0, 8'h09);
    cmd(8'h00);
    rd(4'h5, 8'h10, 8'h10);
    i_x_value = 16'h1234;
    tick(32);
    rd(4'h1, 8'hff, 8'h23);
    rd(4'h5, 8'h0f, 8'h03);
    cmd(8'h81);
    rd(4'h5, 8'h10, 8'h10);
    cmd(8'h00);
    rd(4'h1, 8'hff, 8'h34);
    rd(4'h2, 8'hff, 8'h12);
    rd(4'h5, 8'h0f, 8'h04);
    fault(4'hf);
    rd(4'hf, 8'hff, 8'h93);
    rd(4'hf, 8'hff, 8'h03);
    fault(4'h5);
    rd(4'h5, 8'h40, 8'h40);
    rd(4'h5, 8'h40, 8'h00);
    wr(4'h0, 8'h02);
    i_mux_ok = 1'b0;
    rd(4'h5, 8'h20, 8'h20);
    i_mux_ok = 1'b1;
    rd(4'h5, 8'h20, 8'h00);
    wr(4'h7, 8'h6b);
    `CHK({o_angle_test_on, o_test_value_y_sel, o_test_value_x_sel}, 7'h6b)
    rd(4'h5, 8'h2f, 8'h20);
    tick(64);
    repeat (4) @(negedge i_clk);
    `CHK(o_angle_test_on, 1'b0)
    rd(4'h5, 8'h3f, 8'h10);
    wr(4'he, 8'h00);
    wr(4'hf, 8'h01);
    `CHK(o_node_index, 2'h3)
    wr(4'h7, 8'h40);
    wr(4'h7, 8'h00);
    `CHK(o_angle_test_on, 1'b0)
    print_verdict();
  end
endmodule
